// *** rtl/ptg_pulse_train_gen.sv ***
// Overview of operation
// [RL1] Pulses go to one of two selected outputs.
// [RL2] Pulse rate follows frequency field, up to 20 kHz.
// [RL3] Frequency outside zero to 20000 flags error.
// [RL4] Emit exactly total count, stop, await restart.
// [RL5] Ramp count pulses used for accel and decel.
// [RL6] Run until count done or hard stop.
// [RL7] Hard stop halts output, error code one.
// [RL8] Error clears when run and stop low.
// [RL9] New total count applies only at next start.
// [RL10] Frequency ramps up, then down before end.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
module ptg_pulse_train_gen
  import ptg_pkg::*;
#(
  parameter int CLK_HZ = ptg_pkg::PTG_CLK_HZ,
  parameter int LVL_W = 8
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Discrete outputs.
  output logic out0_o,
  output logic out1_o
);
  import ptg_pkg::*;

  localparam int ACC_W = 40;
  localparam logic [ACC_W-1:0] CLK_HZ_W = ACC_W'(CLK_HZ);
  localparam logic [LVL_W-1:0] LVL_MAX = {LVL_W{1'b1}};

  typedef struct packed {
    ptg_state_type st;
    logic [PTG_CTRL_W-1:0] ctrl;
    logic [31:0] freq;
    logic [31:0] total;
    logic [31:0] ramp;
    logic [31:0] run_total;
    logic [31:0] run_ramp;
    logic run_sel;
    logic [31:0] emitted;
    logic [ACC_W-1:0] acc;
    logic pin;
    logic out0;
    logic out1;
    logic done;
    logic [7:0] err;
    logic ack;
    logic [31:0] dat;
  } ptg_regs_type;

  ptg_regs_type r;
  ptg_regs_type next_r;

  // Merge a bus write into a word under the byte enables.
  function automatic logic [31:0] ptg_merge(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction : ptg_merge

  // True when the signed frequency lies in the legal range.
  function automatic logic ptg_freq_ok(input logic [31:0] f);
    return ($signed(f) >= PTG_FREQ_MIN_HZ) && ($signed(f) <= PTG_FREQ_MAX_HZ);
  endfunction : ptg_freq_ok

  // Saturate a ramp depth to the divider width; deep ramps flatten at the slowest rate.
  function automatic logic [LVL_W-1:0] ptg_sat(input logic [31:0] v);
    return (v > 32'(LVL_MAX)) ? LVL_MAX : v[LVL_W-1:0];
  endfunction : ptg_sat

  logic req;
  logic [31:0] remain;
  logic [LVL_W-1:0] lvl_acc;
  logic [LVL_W-1:0] lvl_dec;
  logic [LVL_W-1:0] lvl;
  logic [ACC_W-1:0] thr;
  logic [ACC_W-1:0] acc_sum;

  // Ramp depth: the slower of the accel and decel profiles sets the rate.
  always_comb
  begin
    req = cyc_i && stb_i;
    remain = r.run_total - r.emitted;
    lvl_acc = '0;
    lvl_dec = '0;
    if (r.emitted < r.run_ramp)
    begin
      lvl_acc = ptg_sat(r.run_ramp - r.emitted); // see [RL10]
    end
    if (remain <= r.run_ramp)
    begin
      lvl_dec = ptg_sat(r.run_ramp - remain + 32'h0000_0001); // see [RL10]
    end
    lvl = (lvl_acc > lvl_dec) ? lvl_acc : lvl_dec; // see [RL5]
    // Half-period threshold grows with depth, so rate is frequency over depth plus one.
    thr = CLK_HZ_W * ACC_W'({1'b0, lvl} + 1'b1);
    acc_sum = r.acc + ACC_W'({r.freq[30:0], 1'b0}); // see [RL2]
  end

  // Next-state logic for bus, control and pulse generation.
  always_comb
  begin
    next_r = r;
    next_r.ack = req && !r.ack;
    // Bus writes; a running total only moves the stored copy.
    if (req && !r.ack && we_i)
    begin
      unique case (adr_i)
        PTG_CTRL_OFS:
        begin
          next_r.ctrl = PTG_CTRL_W'(ptg_merge(32'(r.ctrl), dat_i, sel_i));
        end
        PTG_FREQ_OFS:
        begin
          next_r.freq = ptg_merge(r.freq, dat_i, sel_i);
        end
        PTG_TOTAL_OFS:
        begin
          next_r.total = ptg_merge(r.total, dat_i, sel_i); // see [RL9]
        end
        PTG_RAMP_OFS:
        begin
          next_r.ramp = ptg_merge(r.ramp, dat_i, sel_i);
        end
        default:
        begin
          next_r.ctrl = r.ctrl;
        end
      endcase
    end
    // Bus reads; unmapped addresses read zero.
    next_r.dat = PTG_WORD_RST;
    if (req && !r.ack && !we_i)
    begin
      unique case (adr_i)
        PTG_CTRL_OFS: next_r.dat = 32'(r.ctrl);
        PTG_FREQ_OFS: next_r.dat = r.freq;
        PTG_TOTAL_OFS: next_r.dat = r.total;
        PTG_RAMP_OFS: next_r.dat = r.ramp;
        PTG_STATUS_OFS:
        begin
          next_r.dat[PTG_STAT_RUNNING_BIT] = (r.st == PTG_RUN);
          next_r.dat[PTG_STAT_DONE_BIT] = r.done;
          next_r.dat[PTG_STAT_ERR_LSB +: 8] = r.err;
        end
        PTG_COUNT_OFS: next_r.dat = r.emitted;
        default: next_r.dat = PTG_WORD_RST;
      endcase
    end
    // Generator sequencing.
    unique case (r.st)
      PTG_IDLE:
      begin
        next_r.pin = 1'b0;
        if (r.ctrl[PTG_CTRL_STOP_BIT])
        begin
          next_r.err = PTG_ERR_HARD_STOP; // see [RL7]
          next_r.st = PTG_HALT;
        end
        else if (r.ctrl[PTG_CTRL_RUN_BIT])
        begin
          if (!ptg_freq_ok(r.freq))
          begin
            next_r.err = PTG_ERR_FREQ; // see [RL3]
            next_r.st = PTG_HALT;
          end
          else
          begin
            // Latch count, ramp and output choice for the whole run.
            next_r.run_total = r.total; // see [RL9]
            next_r.run_ramp = r.ramp;
            next_r.run_sel = r.ctrl[PTG_CTRL_SEL_BIT];
            next_r.emitted = PTG_WORD_RST;
            next_r.acc = '0;
            next_r.done = 1'b0;
            next_r.st = PTG_RUN;
          end
        end
      end
      PTG_RUN:
      begin
        if (r.ctrl[PTG_CTRL_STOP_BIT])
        begin
          next_r.pin = 1'b0; // see [RL6]
          next_r.err = PTG_ERR_HARD_STOP; // see [RL7]
          next_r.st = PTG_HALT;
        end
        else if (!ptg_freq_ok(r.freq))
        begin
          next_r.pin = 1'b0;
          next_r.err = PTG_ERR_FREQ; // see [RL3]
          next_r.st = PTG_HALT;
        end
        else if (r.emitted == r.run_total)
        begin
          next_r.pin = 1'b0;
          next_r.done = 1'b1; // see [RL4]
          next_r.st = PTG_HALT;
        end
        else if (acc_sum >= thr)
        begin
          // Each crossing is a half period; a pulse counts on its falling edge.
          next_r.acc = acc_sum - thr;
          next_r.pin = !r.pin;
          if (r.pin)
          begin
            next_r.emitted = r.emitted + 32'h0000_0001; // see [RL4]
          end
        end
        else
        begin
          next_r.acc = acc_sum;
        end
      end
      PTG_HALT:
      begin
        next_r.pin = 1'b0;
        if (r.ctrl[PTG_CTRL_STOP_BIT])
        begin
          next_r.err = PTG_ERR_HARD_STOP; // see [RL7]
        end
        else if (!r.ctrl[PTG_CTRL_RUN_BIT])
        begin
          next_r.err = PTG_ERR_NONE; // see [RL8]
          next_r.st = PTG_IDLE;
        end
      end
      default:
      begin
        next_r.st = PTG_IDLE;
      end
    endcase
    // Only the selected output ever carries the train.
    next_r.out0 = next_r.pin && !next_r.run_sel; // see [RL1]
    next_r.out1 = next_r.pin && next_r.run_sel; // see [RL1]
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.st <= PTG_IDLE;
      r.ctrl <= PTG_CTRL_RST;
      r.err <= PTG_ERR_NONE;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign dat_o = r.dat;
  assign ack_o = r.ack;
  assign out0_o = r.out0;
  assign out1_o = r.out1;

endmodule : ptg_pulse_train_gen

// *** rtl/ptg_pkg.sv ***
package ptg_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] PTG_CTRL_OFS = 8'h00;
  localparam logic [7:0] PTG_FREQ_OFS = 8'h04;
  localparam logic [7:0] PTG_TOTAL_OFS = 8'h08;
  localparam logic [7:0] PTG_RAMP_OFS = 8'h0C;
  localparam logic [7:0] PTG_STATUS_OFS = 8'h10;
  localparam logic [7:0] PTG_COUNT_OFS = 8'h14;

  // Control register field positions.
  localparam int PTG_CTRL_RUN_BIT = 0;
  localparam int PTG_CTRL_STOP_BIT = 1;
  localparam int PTG_CTRL_SEL_BIT = 2;
  localparam int PTG_CTRL_W = 3;

  // Status register field positions.
  localparam int PTG_STAT_RUNNING_BIT = 0;
  localparam int PTG_STAT_DONE_BIT = 1;
  localparam int PTG_STAT_ERR_LSB = 8;

  // Reset values.
  localparam logic [PTG_CTRL_W-1:0] PTG_CTRL_RST = 3'h0;
  localparam logic [31:0] PTG_WORD_RST = 32'h0000_0000;

  // Frequency limits in hertz.
  localparam logic signed [31:0] PTG_FREQ_MIN_HZ = 32'sh0000_0000;
  localparam logic signed [31:0] PTG_FREQ_MAX_HZ = 32'sh0000_4E20;

  // Error codes.
  localparam logic [7:0] PTG_ERR_NONE = 8'h00;
  localparam logic [7:0] PTG_ERR_HARD_STOP = 8'h01;
  localparam logic [7:0] PTG_ERR_FREQ = 8'h02;

  // Clock rate in hertz.
  localparam int PTG_CLK_HZ = 25_000_000;

  // Generator states, Gray coded along idle, run, halt.
  typedef enum logic [1:0]
  {
    PTG_IDLE = 2'b00,
    PTG_RUN = 2'b01,
    PTG_HALT = 2'b11
  } ptg_state_type;

endpackage : ptg_pkg

// *** verification/ptg_pulse_train_gen_asserts.sv ***
module ptg_pulse_train_gen_asserts
  import ptg_pkg::*;
#(
  parameter int CLK_HZ = PTG_CLK_HZ,
  parameter int LVL_W = 8
)
(
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pulse pins.
  input wire logic out0_o,
  input wire logic out1_o
);
  localparam int MIN_LO = CLK_HZ / 40000 - 1;
  int lo_cnt;
  logic req;
  logic stop_wr;
  // A low phase shorter than the top rate allows means too fast a pulse.
  assign req = cyc_i && stb_i && !ack_o;
  assign stop_wr = req && we_i && adr_i == PTG_CTRL_OFS && sel_i[0] && dat_i[PTG_CTRL_STOP_BIT];
  always_ff @(posedge clk_i) lo_cnt <= (out0_o || out1_o) ? 0 : lo_cnt + 1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_req: assert property (req |=> ack_o) else $error("ack missing");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_has_req: assert property (ack_o |-> $past(req)) else $error("ack without request");
  a_read_data_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("stray read data");
  a_one_output: assert property (!(out0_o && out1_o)) else $error("two pins");
  a_stop_halts_pins: assert property (stop_wr |=> ##2 (!out0_o && !out1_o) [*3])
    else $error("pins run after stop");
  a_rate_limit: assert property ($rose(out0_o || out1_o) |-> lo_cnt >= MIN_LO)
    else $error("pulse rate too high");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !out0_o && !out1_o)
    else $error("outputs active in reset");
  c_write: cover property (req && we_i);
  c_pin0: cover property ($rose(out0_o));
  c_pin1: cover property ($rose(out1_o));
  c_stop: cover property (stop_wr);
endmodule : ptg_pulse_train_gen_asserts

bind ptg_pulse_train_gen ptg_pulse_train_gen_asserts #(.CLK_HZ(CLK_HZ), .LVL_W(LVL_W)) u_chk
  (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .out0_o(out0_o), .out1_o(out1_o));

// *** verification/ptg_drive_model.sv ***
module ptg_drive_model
(
  // Clock, reset and step input.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  // Steps taken.
  output int steps_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  // A drive steps on each completed pulse; it cannot push back on the source.
  always_ff @(posedge clk_i)
  begin
    last <= rst_i ? 1'b0 : pin_i;
    steps_o <= rst_i ? 0 : steps_o + int'(last && !pin_i);
  end
endmodule : ptg_drive_model

// *** verification/test_pulse_train_output.sv ***
module test_pulse_train_output
  import ptg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, out0_o, out1_o;
  logic [7:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, rd, tot[3];
  logic [31:0] bad[2] = '{32'h0000_4E21, 32'hFFFF_FFFF};
  int fail_count = 0, tests_run = 0, cyc_n = 0, n0, n1, p0, p1, hi_n = 0, ph;
  localparam int BENCH_HZ = 200000;
  // A low bench clock setting keeps each pulse ten cycles long at the top rate.
  ptg_pulse_train_gen #(.CLK_HZ(BENCH_HZ), .LVL_W(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .out0_o(out0_o), .out1_o(out1_o));
  ptg_drive_model u_drv0 (.clk_i(clk_i), .rst_i(rst_i), .pin_i(out0_o), .steps_o(n0));
  ptg_drive_model u_drv1 (.clk_i(clk_i), .rst_i(rst_i), .pin_i(out1_o), .steps_o(n1));
  // Clock, a hang guard and a tally of cycles with a pin high.
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc_n++;
    hi_n += int'(out0_o || out1_o);
    if (cyc_n == 60000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task check(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : check
  // High cycles of a whole run; ramp pulses at either end run slower by their depth plus one.
  function automatic int exp_high(int total, int ramp, int freq);
    int depth;
    exp_high = 0;
    for (int k = 0; k < total; k++)
    begin
      depth = (k < ramp) ? ramp - k : 0;
      if (total - k <= ramp && ramp - (total - k) + 1 > depth)
      begin
        depth = ramp - (total - k) + 1;
      end
      exp_high += (depth + 1) * BENCH_HZ / (2 * freq);
    end
  endfunction : exp_high
  // One classic cycle; the request stands until ack is sampled high.
  task wb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  task run_ctrl(logic [31:0] c);
    p0 = n0;
    p1 = n1;
    wb(1, PTG_CTRL_OFS, c);
  endtask : run_ctrl
  initial
  begin
    void'($urandom(32'hF548));
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    wb(1, 8'h20, 32'hFFFF);
    wb(0, 8'h20, 0);
    check("unmapped", 32'h0, rd);
    wb(0, PTG_STATUS_OFS, 0);
    check("status", 32'h0, rd);
    foreach (tot[i]) tot[i] = 3 + $urandom_range(5);
    wb(1, PTG_FREQ_OFS, 32'h0000_4E20);
    wb(1, PTG_TOTAL_OFS, tot[0]);
    for (int i = 0; i < 2; i++)
    begin
      wb(1, PTG_RAMP_OFS, i);
      ph = hi_n;
      run_ctrl(i << PTG_CTRL_SEL_BIT | 1);
      wb(1, PTG_TOTAL_OFS, tot[i + 1]);
      repeat (300) if (rd[PTG_STAT_DONE_BIT] !== 1'b1) wb(0, PTG_STATUS_OFS, 0);
      wb(0, PTG_COUNT_OFS, 0);
      check("count", tot[i], rd);
      check("pulses", tot[i], i ? n1 - p1 : n0 - p0);
      check("other pin", 0, i ? n0 - p0 : n1 - p1);
      check("high time", exp_high(tot[i], i, PTG_FREQ_MAX_HZ), hi_n - ph);
      wb(1, PTG_CTRL_OFS, 0);
    end
    foreach (bad[i])
    begin
      wb(1, PTG_FREQ_OFS, bad[i]);
      run_ctrl(1);
      repeat (40) @(posedge clk_i);
      wb(0, PTG_STATUS_OFS, 0);
      check("freq error", PTG_ERR_FREQ, rd[15:8]);
      check("no pulses", 0, n0 - p0);
      wb(1, PTG_CTRL_OFS, 0);
    end
    wb(1, PTG_FREQ_OFS, 32'h0000_4E20);
    wb(1, PTG_TOTAL_OFS, 40);
    run_ctrl(1);
    repeat (60) @(posedge clk_i);
    wb(1, PTG_CTRL_OFS, 3);
    wb(0, PTG_STATUS_OFS, 0);
    check("stop status", {PTG_ERR_HARD_STOP, 8'h0}, rd[15:0] & 16'hFF01);
    p0 = n0;
    wb(0, PTG_COUNT_OFS, 0);
    check("stopped early", 1, rd < 40);
    repeat (40) @(posedge clk_i);
    check("halted pin", 0, n0 - p0);
    wb(1, PTG_CTRL_OFS, 2);
    wb(0, PTG_STATUS_OFS, 0);
    check("error held", PTG_ERR_HARD_STOP, rd[15:8]);
    wb(1, PTG_CTRL_OFS, 0);
    wb(0, PTG_STATUS_OFS, 0);
    check("error cleared", PTG_ERR_NONE, rd[15:8]);
    end_of_test();
  end
endmodule : test_pulse_train_output
